// ==== inc/ofjm_pkg.sv ====
// Constants, types and register map of the original feeder jam monitor
package ofjm_pkg;

    // Clock and millisecond tick
    localparam int unsigned CLK_FREQ_HZ = 250_000_000;
    localparam int unsigned TICK_PERIOD_MS = 1;
    localparam int unsigned TICK_CYCLES = CLK_FREQ_HZ / 1000 * TICK_PERIOD_MS;
    localparam int DIV_W = 18;

    // Supervision limits in milliseconds
    localparam int LIM_W = 12;
    localparam logic [11:0] T_REG_TS1_MS = 12'd1774;
    localparam logic [11:0] T_REG_TS2_MS = 12'd1014;
    localparam logic [11:0] T_FEED_CLEAR_MS = 12'd2084;
    localparam logic [11:0] T_TS1_OFF_MS = 12'd1416;
    localparam logic [11:0] T_TS2_OFF_MS = 12'd656;
    localparam logic [11:0] T_SB_TRAY_MS = 12'd2318;
    localparam logic [11:0] T_SB_REG_MS = 12'd935;
    localparam logic [11:0] T_EJECT_MS = 12'd1705;
    localparam logic [11:0] T_SB_EJECT_MS = 12'd841;
    localparam logic [2:0] RETRY_MAX = 3'd5;

    // Jam codes
    localparam logic [7:0] JAM_REG = 8'd73;
    localparam logic [7:0] JAM_FEED = 8'd74;
    localparam logic [7:0] JAM_CONVEY = 8'd75;
    localparam logic [7:0] JAM_SB1 = 8'd76;
    localparam logic [7:0] JAM_SB2 = 8'd77;
    localparam logic [7:0] JAM_COVER = 8'd78;
    localparam logic [7:0] JAM_EJECT = 8'd79;

    // Sensor vector positions
    localparam int N_SENS = 7;
    localparam int S_FEED = 0;
    localparam int S_REG = 1;
    localparam int S_TS1 = 2;
    localparam int S_TS2 = 3;
    localparam int S_SBT = 4;
    localparam int S_EJECT = 5;
    localparam int S_COVER = 6;

    // Timer indexes
    localparam int N_TMR = 7;
    localparam int T_REG_TS = 0;
    localparam int T_FEED_CLR = 1;
    localparam int T_TS_OFF = 2;
    localparam int T_SBT = 3;
    localparam int T_SB_REG = 4;
    localparam int T_EJ_ON = 5;
    localparam int T_EJ_OFF = 6;
    localparam int INIT_W = 2;
    localparam logic [1:0] INIT_DONE = 2'h3;

    // Register map (byte addresses)
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_SENSORS = 8'h0C;
    localparam int CTRL_FEEDING = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CMD_ACK = 0;
    localparam int ST_JAM = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_CODE_LSB = 8;
    localparam int ST_RETRY_LSB = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {OFJM_SINGLE, OFJM_DUPLEX_SB, OFJM_DUAL} ofjm_mode_t;

    // Jam report carried to the outputs
    typedef struct packed {
        logic jam;
        logic [7:0] code;
        logic retry;
    } ofjm_report_t;

endpackage

// ==== core/ofjm_monitor.sv ====
// Jam monitor for the original feeder paper path, with an AXI4-Lite register slave
//
// Contract
// (RL1) Single/duplex: timing sensor 1 must rise within 1774 ms of registration rise, else 73.
// (RL2) Dual: timing sensor 2 must rise within 1014 ms of registration rise, else 73.
// (RL3) Registration-to-timing misses are retried five times before jam 73 is reported.
// (RL4) Feed and registration sensors must clear within 2084 ms of timing 1 rise, else 74.
// (RL5) Previous scan still busy when timing sensor 1 rises gives jam 74.
// (RL6) Single/duplex: timing 1 must fall within 1416 ms of registration fall, else 75.
// (RL7) Dual: timing 2 must fall within 656 ms of registration fall, else 75.
// (RL8) Duplex: switchback tray sensor must rise within 2318 ms of timing 1 rise, else 76.
// (RL9) Duplex: registration must rise within 935 ms of switchback start, else 77.
// (RL10) Feeder or top cover open while feeding gives jam 78.
// (RL11) Feed, registration or either timing sensor occupied at power-up or feed start gives jam 78.
// (RL12) Single/dual: eject must rise within 1705 ms of timing 1 rise, else 79.
// (RL13) Duplex: eject must rise within 841 ms of switchback eject start, else 79.
// (RL14) Single/dual: eject must fall within 1705 ms of timing 1 fall, else 79.
// (RL15) Timers arm on trigger edge, count millisecond ticks, cancel on expected edge (feed clear and timing fall cancel on level).
// (RL16) A jam latches its code and flag until reset or acknowledge.
module ofjm_monitor #(
    parameter int unsigned TICK_CYCLES = ofjm_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RST_IN,
    // Paper path switches and cover interlock (asynchronous pins)
    input wire logic FEED_SENSOR_IN,
    input wire logic REG_SENSOR_IN,
    input wire logic TIMING1_SENSOR_IN,
    input wire logic TIMING2_SENSOR_IN,
    input wire logic SB_TRAY_SENSOR_IN,
    input wire logic EJECT_SENSOR_IN,
    input wire logic COVER_OPEN_IN,
    // Feeder sequencer events (same clock)
    input wire logic SCAN_BUSY_IN,
    input wire logic SB_START_IN,
    input wire logic SB_EJECT_START_IN,
    // Jam report
    output logic JAM_OUT,
    output logic [7:0] JAM_CODE_OUT,
    output logic RETRY_OUT,
    // AXI4-Lite write address
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [7:0] AWADDR,
    input wire logic [2:0] AWPROT,
    // AXI4-Lite write data
    input wire logic WVALID,
    output logic WREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    // AXI4-Lite write response
    output logic BVALID,
    input wire logic BREADY,
    output logic [1:0] BRESP,
    // AXI4-Lite read address
    input wire logic ARVALID,
    output logic ARREADY,
    input wire logic [7:0] ARADDR,
    input wire logic [2:0] ARPROT,
    // AXI4-Lite read data
    output logic RVALID,
    input wire logic RREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP
);

    typedef struct packed {
        logic [6:0] sync1;
        logic [6:0] sync2;
        logic [6:0] prev;
        logic [17:0] div;
        logic tick;
        logic [6:0] act;
        logic [6:0][11:0] cnt;
        ofjm_pkg::ofjm_report_t rep;
        logic [2:0] retries;
        logic feeding;
        logic [1:0] mode;
        logic feed_prev;
        logic [1:0] init;
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ofjm_state_t;

    localparam logic [17:0] TICK_LAST = 18'(TICK_CYCLES - 1);

    ofjm_state_t q;
    ofjm_state_t n;
    logic [6:0] sens, rise, fall, arm, cancel, expire;
    logic [6:0][11:0] lim;
    logic [6:0][7:0] tcode;
    logic dual, duplex, run, set_jam, occupied, wr_fire;
    logic [7:0] set_code, wa, ra;

    assign sens = {COVER_OPEN_IN, EJECT_SENSOR_IN, SB_TRAY_SENSOR_IN, TIMING2_SENSOR_IN,
        TIMING1_SENSOR_IN, REG_SENSOR_IN, FEED_SENSOR_IN};

    // Ready outputs are combinational, valid and data outputs registered
    assign AWREADY = !q.aw_got && !q.bvalid;
    assign WREADY = !q.w_got && !q.bvalid;
    assign ARREADY = !q.rvalid;
    assign BVALID = q.bvalid;
    assign BRESP = q.bresp;
    assign RVALID = q.rvalid;
    assign RDATA = q.rdata;
    assign RRESP = q.rresp;
    assign JAM_OUT = q.rep.jam;
    assign JAM_CODE_OUT = q.rep.code;
    assign RETRY_OUT = q.rep.retry;

    //////////////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        n = q;
        arm = '0;
        cancel = '0;
        expire = '0;
        lim = '0;
        tcode = '0;
        set_jam = 1'b0;
        set_code = '0;
        wa = '0;
        ra = '0;
        wr_fire = 1'b0;

        // Pins pass two flops; the third stage is the edge reference
        n.sync1 = sens;
        n.sync2 = q.sync1;
        n.prev = q.sync2;
        rise = q.sync2 & ~q.prev;
        fall = ~q.sync2 & q.prev;
        dual = (q.mode == ofjm_pkg::OFJM_DUAL);
        duplex = (q.mode == ofjm_pkg::OFJM_DUPLEX_SB);
        occupied = q.sync2[ofjm_pkg::S_FEED] | q.sync2[ofjm_pkg::S_REG]
            | q.sync2[ofjm_pkg::S_TS1] | q.sync2[ofjm_pkg::S_TS2];

        // Millisecond tick
        n.tick = (q.div == TICK_LAST); // RL15
        n.div = n.tick ? '0 : q.div + 18'h00001;

        // Trigger and expected edges per timer, limits per mode
        arm[ofjm_pkg::T_REG_TS] = rise[ofjm_pkg::S_REG]; // RL1
        cancel[ofjm_pkg::T_REG_TS] = dual ? rise[ofjm_pkg::S_TS2] : rise[ofjm_pkg::S_TS1]; // RL2
        lim[ofjm_pkg::T_REG_TS] = dual ? ofjm_pkg::T_REG_TS2_MS : ofjm_pkg::T_REG_TS1_MS; // RL1
        tcode[ofjm_pkg::T_REG_TS] = ofjm_pkg::JAM_REG;

        arm[ofjm_pkg::T_FEED_CLR] = rise[ofjm_pkg::S_TS1]; // RL4
        cancel[ofjm_pkg::T_FEED_CLR] = !q.sync2[ofjm_pkg::S_FEED] && !q.sync2[ofjm_pkg::S_REG];
        lim[ofjm_pkg::T_FEED_CLR] = ofjm_pkg::T_FEED_CLEAR_MS;
        tcode[ofjm_pkg::T_FEED_CLR] = ofjm_pkg::JAM_FEED;
        // Level cancel: a sheet short of the sensor is the arrival check's case
        arm[ofjm_pkg::T_TS_OFF] = fall[ofjm_pkg::S_REG]; // RL6
        cancel[ofjm_pkg::T_TS_OFF] = !(dual ? q.sync2[ofjm_pkg::S_TS2] : q.sync2[ofjm_pkg::S_TS1]);
        lim[ofjm_pkg::T_TS_OFF] = dual ? ofjm_pkg::T_TS2_OFF_MS : ofjm_pkg::T_TS1_OFF_MS; // RL7
        tcode[ofjm_pkg::T_TS_OFF] = ofjm_pkg::JAM_CONVEY;
        arm[ofjm_pkg::T_SBT] = duplex && rise[ofjm_pkg::S_TS1]; // RL8
        cancel[ofjm_pkg::T_SBT] = rise[ofjm_pkg::S_SBT];
        lim[ofjm_pkg::T_SBT] = ofjm_pkg::T_SB_TRAY_MS;
        tcode[ofjm_pkg::T_SBT] = ofjm_pkg::JAM_SB1;
        arm[ofjm_pkg::T_SB_REG] = duplex && SB_START_IN; // RL9
        cancel[ofjm_pkg::T_SB_REG] = rise[ofjm_pkg::S_REG];
        lim[ofjm_pkg::T_SB_REG] = ofjm_pkg::T_SB_REG_MS;
        tcode[ofjm_pkg::T_SB_REG] = ofjm_pkg::JAM_SB2;

        arm[ofjm_pkg::T_EJ_ON] = duplex ? SB_EJECT_START_IN : rise[ofjm_pkg::S_TS1]; // RL12 RL13
        cancel[ofjm_pkg::T_EJ_ON] = rise[ofjm_pkg::S_EJECT];
        lim[ofjm_pkg::T_EJ_ON] = duplex ? ofjm_pkg::T_SB_EJECT_MS : ofjm_pkg::T_EJECT_MS; // RL13
        tcode[ofjm_pkg::T_EJ_ON] = ofjm_pkg::JAM_EJECT;

        arm[ofjm_pkg::T_EJ_OFF] = !duplex && fall[ofjm_pkg::S_TS1]; // RL14
        cancel[ofjm_pkg::T_EJ_OFF] = fall[ofjm_pkg::S_EJECT];
        lim[ofjm_pkg::T_EJ_OFF] = ofjm_pkg::T_EJECT_MS;
        tcode[ofjm_pkg::T_EJ_OFF] = ofjm_pkg::JAM_EJECT;

        // Timers only supervise an unjammed feed; a jam stops the whole path
        run = q.feeding && !q.rep.jam;
        for (int i = 0; i < ofjm_pkg::N_TMR; i++)
        begin
            if (!run || cancel[i])
            begin
                n.act[i] = 1'b0; // RL15
            end
            else if (arm[i])
            begin
                n.act[i] = 1'b1; // RL15
                n.cnt[i] = '0;
            end
            else if (q.act[i] && q.tick)
            begin
                expire[i] = (q.cnt[i] == lim[i] - 12'h001); // RL15
                n.act[i] = !expire[i];
                n.cnt[i] = q.cnt[i] + 12'h001;
            end
        end

        // Registration misses retry before reporting
        n.rep.retry = 1'b0;
        if (run && cancel[ofjm_pkg::T_REG_TS] && q.act[ofjm_pkg::T_REG_TS])
        begin
            n.retries = '0;
        end
        if (expire[ofjm_pkg::T_REG_TS])
        begin
            if (q.retries == ofjm_pkg::RETRY_MAX)
            begin
                set_jam = 1'b1; // RL3
                set_code = ofjm_pkg::JAM_REG;
            end
            else
            begin
                n.retries = q.retries + 3'h1; // RL3
                n.rep.retry = 1'b1;
            end
        end

        // Lowest timer index above 0 wins when several expire together; registration timer 0 loses to any of them
        for (int i = ofjm_pkg::N_TMR - 1; i > 0; i--)
        begin
            if (expire[i])
            begin
                set_jam = 1'b1;
                set_code = tcode[i];
            end
        end
        if (run && rise[ofjm_pkg::S_TS1] && SCAN_BUSY_IN)
        begin
            set_jam = 1'b1; // RL5
            set_code = ofjm_pkg::JAM_FEED;
        end
        if (run && q.sync2[ofjm_pkg::S_COVER])
        begin
            set_jam = 1'b1; // RL10
            set_code = ofjm_pkg::JAM_COVER;
        end

        // Power-up check waits until the synchronisers hold real pin levels
        if (q.init != ofjm_pkg::INIT_DONE)
        begin
            n.init = q.init + 2'h1;
        end
        n.feed_prev = q.feeding;
        if (occupied && ((q.init == ofjm_pkg::INIT_DONE - 2'h1)
            || (q.feeding && !q.feed_prev)))
        begin
            set_jam = 1'b1; // RL11
            set_code = ofjm_pkg::JAM_COVER;
        end
        if (q.feeding && !q.feed_prev)
        begin
            n.retries = '0;
        end

        //////////////////////////////////////////////////////////////////////////////////////
        // AXI4-Lite write path: address and data in either order
        if (AWVALID && AWREADY)
        begin
            n.aw_got = 1'b1;
            n.awaddr = AWADDR;
        end
        if (WVALID && WREADY)
        begin
            n.w_got = 1'b1;
            n.wdata = WDATA;
            n.wstrb = WSTRB;
        end
        if (q.aw_got && q.w_got)
        begin
            wr_fire = 1'b1;
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = ofjm_pkg::RESP_OKAY;
            wa = {q.awaddr[7:2], 2'h0};
            if (wa == ofjm_pkg::REG_CTRL)
            begin
                if (q.wstrb[0])
                begin
                    n.feeding = q.wdata[ofjm_pkg::CTRL_FEEDING];
                    n.mode = q.wdata[ofjm_pkg::CTRL_MODE_LSB +: 2];
                end
            end
            else if (wa == ofjm_pkg::REG_CMD)
            begin
                if (q.wstrb[0] && q.wdata[ofjm_pkg::CMD_ACK])
                begin
                    n.rep.jam = 1'b0; // RL16
                    n.rep.code = '0;
                    n.retries = '0;
                end
            end
            else if (wa != ofjm_pkg::REG_STATUS && wa != ofjm_pkg::REG_SENSORS)
            begin
                n.bresp = ofjm_pkg::RESP_SLVERR;
            end
        end
        if (q.bvalid && BREADY)
        begin
            n.bvalid = 1'b0;
        end

        // Read path: one cycle from address to data
        if (ARVALID && ARREADY)
        begin
            ra = {ARADDR[7:2], 2'h0};
            n.rvalid = 1'b1;
            n.rdata = '0;
            n.rresp = ofjm_pkg::RESP_OKAY;
            case (ra)
                ofjm_pkg::REG_CTRL:
                begin
                    n.rdata[ofjm_pkg::CTRL_FEEDING] = q.feeding;
                    n.rdata[ofjm_pkg::CTRL_MODE_LSB +: 2] = q.mode;
                end
                ofjm_pkg::REG_CMD: n.rdata = '0;
                ofjm_pkg::REG_STATUS:
                begin
                    n.rdata[ofjm_pkg::ST_JAM] = q.rep.jam;
                    n.rdata[ofjm_pkg::ST_BUSY] = |q.act;
                    n.rdata[ofjm_pkg::ST_CODE_LSB +: 8] = q.rep.code;
                    n.rdata[ofjm_pkg::ST_RETRY_LSB +: 3] = q.retries;
                end
                ofjm_pkg::REG_SENSORS:
                begin
                    n.rdata[ofjm_pkg::N_SENS - 1:0] = q.sync2;
                end
                default:
                begin
                    n.rresp = ofjm_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (q.rvalid && RREADY)
        begin
            n.rvalid = 1'b0;
        end

        // First jam is kept; a new jam beats a same-cycle acknowledge
        if (set_jam && !n.rep.jam)
        begin
            n.rep.jam = 1'b1; // RL16
            n.rep.code = set_code;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            q <= '0;
        end
        else
        begin
            q <= n;
        end
    end

endmodule

// ==== dv/ofjm_checker.sv ====
// Port assertions for the feeder jam monitor
module ofjm_checker #(
    parameter int unsigned TICK_CYCLES = 4
) (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RST_IN,
    // Jam report
    input wire logic JAM_OUT,
    input wire logic [7:0] JAM_CODE_OUT,
    input wire logic RETRY_OUT,
    // Register bus answers
    input wire logic BVALID,
    input wire logic BREADY,
    input wire logic [1:0] BRESP,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic RVALID,
    input wire logic RREADY,
    input wire logic [31:0] RDATA,
    input wire logic [1:0] RRESP
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (RST_IN);
    ////////////////////////////////////////
    // Only a command write may clear a jam; its answer stands beside the clear
    property p_jam_hold;
        $fell(JAM_OUT) |-> BVALID || $past(BVALID);
    endproperty
    a_jam_hold: assert property (p_jam_hold)
        else $error("jam cleared without a command write");
    property p_code_stable;
        JAM_OUT && $past(JAM_OUT) |-> $stable(JAM_CODE_OUT);
    endproperty
    a_code_stable: assert property (p_code_stable)
        else $error("jam code changed while held");
    property p_code_set;
        $rose(JAM_OUT) |-> JAM_CODE_OUT inside {[ofjm_pkg::JAM_REG:ofjm_pkg::JAM_EJECT]};
    endproperty
    a_code_set: assert property (p_code_set)
        else $error("jam raised with a code out of range");
    property p_code_idle;
        !JAM_OUT |-> JAM_CODE_OUT == 8'h00;
    endproperty
    a_code_idle: assert property (p_code_idle)
        else $error("code shown without a jam");
    property p_retry_pulse;
        RETRY_OUT |-> !JAM_OUT ##1 !RETRY_OUT;
    endproperty
    a_retry_pulse: assert property (p_retry_pulse)
        else $error("retry request not a lone pulse");
    property p_reset_out;
        $past(RST_IN) |-> !JAM_OUT && !RETRY_OUT && !BVALID && !RVALID;
    endproperty
    a_reset_out: assert property (p_reset_out)
        else $error("outputs not idle after reset");
    property p_b_stand;
        BVALID && !BREADY |=> BVALID && $stable(BRESP);
    endproperty
    a_b_stand: assert property (p_b_stand)
        else $error("write answer withdrawn early");
    property p_r_stand;
        RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP);
    endproperty
    a_r_stand: assert property (p_r_stand)
        else $error("read answer withdrawn early");
    property p_r_answer;
        ARVALID && ARREADY |=> RVALID && !ARREADY;
    endproperty
    a_r_answer: assert property (p_r_answer)
        else $error("read not answered on the next cycle");
endmodule

// ==== dv/ofjm_feeder.sv ====
// Behavioural model of the feeder paper-path switches and cover interlock
module ofjm_feeder (
    // Clock
    input wire logic clk_in,
    // Levels {cover, eject, tray, ts2, ts1, reg, feed}
    output logic [6:0] sens_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial sens_out = 7'h00;
    // Delay d models a slow sheet; call only right after a rising edge
    task automatic put(input logic [6:0] v, input int d);
        repeat (d) @(posedge clk_in);
        sens_out <= v;
    endtask
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench of the feeder jam monitor
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // Short tick keeps the millisecond limits affordable
    localparam int TK = 2;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic busy = 1'b0;
    logic sbs = 1'b0;
    logic sbe = 1'b0;
    logic awv = 1'b0;
    logic wv = 1'b0;
    logic bre = 1'b0;
    logic arv = 1'b0;
    logic rre = 1'b0;
    logic [7:0] awa = 8'h00;
    logic [7:0] ara = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [6:0] sens;
    logic jam, retry, awr, wrdy, bv, arr, rv;
    logic [7:0] code;
    logic [1:0] br, rr;
    logic [31:0] rd;
    int mismatches = 0;
    int n_checks = 0;
    int cyc_n = 0;
    int exp_q[$];
    // Timer cases: mode, switch levels in turn, step that arms the timer
    int sc_mode[6] = '{0, 0, 0, 0, 2, 1};
    int sc_k[6] = '{1, 1, 3, 4, 2, 1};
    logic [6:0] sc_m[6][5] = '{'{7'h02, 7'h06, 7'h06, 7'h06, 7'h06},
        '{7'h02, 7'h06, 7'h26, 7'h26, 7'h26}, '{7'h02, 7'h06, 7'h26, 7'h24, 7'h24},
        '{7'h02, 7'h06, 7'h26, 7'h24, 7'h20}, '{7'h02, 7'h0A, 7'h08, 7'h08, 7'h08},
        '{7'h02, 7'h06, 7'h04, 7'h00, 7'h00}};
    logic [7:0] sc_code[6] = '{ofjm_pkg::JAM_EJECT, ofjm_pkg::JAM_FEED, ofjm_pkg::JAM_CONVEY,
        ofjm_pkg::JAM_EJECT, ofjm_pkg::JAM_CONVEY, ofjm_pkg::JAM_SB1};
    logic [11:0] sc_lim[6] = '{ofjm_pkg::T_EJECT_MS, ofjm_pkg::T_FEED_CLEAR_MS,
        ofjm_pkg::T_TS1_OFF_MS, ofjm_pkg::T_EJECT_MS, ofjm_pkg::T_TS2_OFF_MS,
        ofjm_pkg::T_SB_TRAY_MS};
    always #2 clk = ~clk;
    always @(posedge clk) cyc_n <= cyc_n + 1;
    ofjm_feeder ofjm_feeder_inst (.clk_in(clk), .sens_out(sens));
    ofjm_monitor #(.TICK_CYCLES(TK)) ofjm_monitor_inst (
        .CLK_IN(clk), .RST_IN(rst), .FEED_SENSOR_IN(sens[0]), .REG_SENSOR_IN(sens[1]),
        .TIMING1_SENSOR_IN(sens[2]), .TIMING2_SENSOR_IN(sens[3]), .SB_TRAY_SENSOR_IN(sens[4]),
        .EJECT_SENSOR_IN(sens[5]), .COVER_OPEN_IN(sens[6]), .SCAN_BUSY_IN(busy),
        .SB_START_IN(sbs), .SB_EJECT_START_IN(sbe), .JAM_OUT(jam), .JAM_CODE_OUT(code),
        .RETRY_OUT(retry), .AWVALID(awv), .AWREADY(awr), .AWADDR(awa), .AWPROT(3'h0),
        .WVALID(wv), .WREADY(wrdy), .WDATA(wd), .WSTRB(4'hF), .BVALID(bv), .BREADY(bre),
        .BRESP(br), .ARVALID(arv), .ARREADY(arr), .ARADDR(ara), .ARPROT(3'h0),
        .RVALID(rv), .RREADY(rre), .RDATA(rd), .RRESP(rr));
    ////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Jam must land between limit-1 ticks and limit ticks plus 8 cycles after the arming edge
    function automatic logic [31:0] in_win(input int t0, input int lim);
        return 32'(cyc_n - t0 >= (lim - 1) * TK && cyc_n - t0 <= lim * TK + 8);
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta;
        logic tw;
        ta = 1'b0;
        tw = 1'b0;
        awv <= 1'b1;
        awa <= a;
        wv <= 1'b1;
        wd <= d;
        while (!(ta && tw))
        begin
            @(posedge clk);
            ta = ta || awr === 1'b1;
            tw = tw || wrdy === 1'b1;
            awv <= !ta;
            wv <= !tw;
        end
        repeat ($urandom_range(0, 2)) @(posedge clk);
        bre <= 1'b1;
        do @(posedge clk); while (bv !== 1'b1);
        bre <= 1'b0;
        chk(32'(br), 32'(er));
    endtask
    task automatic rdr(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
        arv <= 1'b1;
        ara <= a;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        repeat ($urandom_range(0, 2)) @(posedge clk);
        rre <= 1'b1;
        do @(posedge clk); while (rv !== 1'b1);
        rre <= 1'b0;
        d = rd;
        chk(32'(rr), 32'(er));
    endtask
    task automatic go(input int m);
        wr(ofjm_pkg::REG_CTRL, 32'h0, ofjm_pkg::RESP_OKAY);
        wr(ofjm_pkg::REG_CTRL, 32'(m * 2 + 1), ofjm_pkg::RESP_OKAY);
    endtask
    task automatic exp_jam(input int lim, input int t0);
        logic [31:0] d;
        logic [31:0] e;
        e = 32'(exp_q.pop_front());
        while (jam !== 1'b1 && cyc_n - t0 < lim * TK + 30)
            @(posedge clk);
        chk(in_win(t0, lim), 32'h1);
        chk(32'(code), e);
        rdr(ofjm_pkg::REG_STATUS, ofjm_pkg::RESP_OKAY, d);
        chk(d & 32'h0000FF01, e << 8 | 32'h1);
    endtask
    task automatic clr(input string nm);
        wr(ofjm_pkg::REG_CTRL, 32'h0, ofjm_pkg::RESP_OKAY);
        ofjm_feeder_inst.put(7'h00, 0);
        busy <= 1'b0;
        repeat (6) @(posedge clk);
        wr(ofjm_pkg::REG_CMD, 32'h1, ofjm_pkg::RESP_OKAY);
        chk(32'({jam, code}), 32'h0);
        $display("test %s done", nm);
    endtask
    ////////////////////////////////////////
    initial
    begin
        repeat (80000) @(posedge clk);
        mismatches++;
        $display("watchdog expired");
        finish_test();
    end
    initial
    begin
        int t0;
        int lim;
        logic [31:0] d;
        t0 = $urandom(32'h71981B21);
        @(posedge clk);
        ofjm_feeder_inst.put(7'h01, 0);
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t0 = cyc_n;
        exp_q.push_back(ofjm_pkg::JAM_COVER);
        exp_jam(0, t0);
        clr("power-up");
        rdr(ofjm_pkg::REG_CMD, ofjm_pkg::RESP_OKAY, d);
        chk(d, 32'h0);
        rdr(8'h40, ofjm_pkg::RESP_SLVERR, d);
        chk(d, 32'h0);
        wr(8'h40, 32'h1, ofjm_pkg::RESP_SLVERR);
        wr(ofjm_pkg::REG_CTRL, 32'h5, ofjm_pkg::RESP_OKAY);
        rdr(ofjm_pkg::REG_CTRL, ofjm_pkg::RESP_OKAY, d);
        chk(d, 32'h5);
        ofjm_feeder_inst.put(7'h40, 1);
        t0 = cyc_n;
        exp_q.push_back(ofjm_pkg::JAM_COVER);
        exp_jam(0, t0);
        clr("cover");
        ofjm_feeder_inst.put(7'h08, 1);
        repeat (4) @(posedge clk);
        t0 = cyc_n;
        exp_q.push_back(ofjm_pkg::JAM_COVER);
        wr(ofjm_pkg::REG_CTRL, 32'h1, ofjm_pkg::RESP_OKAY);
        exp_jam(0, t0);
        clr("occupied");
        foreach (sc_code[i])
        begin
            go(sc_mode[i]);
            for (int j = 0; j < 5; j++)
            begin
                ofjm_feeder_inst.put(sc_m[i][j], $urandom_range(1, 40));
                if (j == sc_k[i])
                    t0 = cyc_n;
            end
            exp_q.push_back(sc_code[i]);
            exp_jam(int'(sc_lim[i]), t0);
            clr("timer");
        end
        go(0);
        busy <= 1'b1;
        ofjm_feeder_inst.put(7'h02, 1);
        ofjm_feeder_inst.put(7'h06, 5);
        t0 = cyc_n;
        exp_q.push_back(ofjm_pkg::JAM_FEED);
        exp_jam(0, t0);
        clr("scan busy");
        for (int j = 0; j < 2; j++)
        begin
            go(1);
            t0 = cyc_n;
            sbs <= j == 0;
            sbe <= j == 1;
            @(posedge clk);
            sbs <= 1'b0;
            sbe <= 1'b0;
            exp_q.push_back(j == 0 ? ofjm_pkg::JAM_SB2 : ofjm_pkg::JAM_EJECT);
            exp_jam(j == 0 ? 935 : 841, t0);
            clr("switchback");
        end
        for (int m = 0; m < 3; m += 2)
        begin
            go(m);
            lim = m == 2 ? int'(ofjm_pkg::T_REG_TS2_MS) : int'(ofjm_pkg::T_REG_TS1_MS);
            for (int r = 0; r < (m == 2 ? 6 : 1); r++)
            begin
                ofjm_feeder_inst.put(7'h00, 2);
                ofjm_feeder_inst.put(7'h02, 2);
                t0 = cyc_n;
                if (r == 5)
                begin
                    exp_q.push_back(ofjm_pkg::JAM_REG);
                    exp_jam(lim, t0);
                end
                else
                begin
                    while (retry !== 1'b1 && cyc_n - t0 < lim * TK + 30)
                        @(posedge clk);
                    chk(32'({retry, jam}), 32'h2);
                    chk(in_win(t0, lim), 32'h1);
                end
            end
            clr("retry");
        end
        finish_test();
    end
endmodule

bind ofjm_monitor ofjm_checker #(.TICK_CYCLES(TICK_CYCLES)) ofjm_checker_inst (
    .CLK_IN(CLK_IN), .RST_IN(RST_IN), .JAM_OUT(JAM_OUT), .JAM_CODE_OUT(JAM_CODE_OUT),
    .RETRY_OUT(RETRY_OUT), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY),
    .RDATA(RDATA), .RRESP(RRESP));
